// ==== record_buffer.sv ====
// Behaviour
// R01: select 0x200..0x2FF exposes logical entry select minus 0x200 via aliases.
// R02: alias one source, two target, three metadata; four to six read zero.
// R03: guest select window reaches the same entry storage as supervisor window.
// R04: source and target hold every valid pc; writes stored as legal values.
// R05: narrow word width zero-extends software and recorded pc values.
// R06: mispredict flag set for mispredicted transfers, zero otherwise.
// R07: metadata is 64 bits; unimplemented bits read zero.
// R08: four-bit transfer kind recorded in metadata.
// R09: metadata holds count-valid flag and 16-bit exponent/mantissa count.
// R10: clear zeroes all entries, the cycle counter and count-valid state.
// R11: reads after clear return zero; first record after clear has valid zero.
// R12: clear faults illegal in user mode, virtual in guest user mode.
// R13: machine gate low below machine: entry access and clear fault illegal.
// R14: recording continues while software access is gated off.
// R15: hypervisor gate reads zero while machine gate is zero.
// R16: machine gate on, hypervisor off: guest access and clear fault virtual.
// R17: record only if mode enabled, type allowed, not frozen, and retired.
// R18: new record enters logical entry 0; oldest is dropped when full.
// R19: each record sets the source valid flag and all implemented fields.
// R20: traps: both enabled normal; disabled-to-enabled source zero; else none.
// R21: returns: both enabled normal; enabled-to-disabled target zero; else none.
// R22: nothing recorded in debug mode or on transfers entering or leaving it.
// R23: logical X maps to physical (pointer minus X minus 1) modulo depth.
// R24: entries from configured depth to 255 read zero and ignore writes.
module record_buffer
  import record_buffer_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  // privilege state
  input  wire logic [1:0]        i_priv,
  input  wire logic              i_virt,
  input  wire logic              i_narrow_width,
  input  wire logic              i_machine_state_gate,
  input  wire logic              i_hyper_state_gate,
  input  wire logic [2:0]        i_depth_sel,
  input  wire logic              i_frozen,
  // indirect alias access
  input  wire logic              i_csr_valid,
  input  wire logic              i_csr_write,
  input  wire logic [2:0]        i_csr_alias,
  input  wire logic [WORD_W-1:0] i_csr_wdata,
  input  wire logic [SEL_W-1:0]  i_sup_select,
  input  wire logic [SEL_W-1:0]  i_vs_select,
  // clear instruction
  input  wire logic              i_record_clear_op,
  // retired transfer
  input  wire logic              i_retire_valid,
  input  wire logic [WORD_W-1:0] i_retire_src_pc,
  input  wire logic [WORD_W-1:0] i_retire_tgt_pc,
  input  wire logic [3:0]        i_retire_kind,
  input  wire logic              i_retire_mispredict,
  input  wire logic              i_retire_inhibit,
  input  wire logic              i_retire_is_trap,
  input  wire logic              i_retire_is_return,
  input  wire logic              i_src_mode_enabled,
  input  wire logic              i_tgt_mode_enabled,
  input  wire logic              i_in_debug,
  input  wire logic              i_debug_crossing,
  // answers
  output logic                   o_csr_done,
  output logic                   o_csr_hit,
  output logic [WORD_W-1:0]      o_csr_rdata,
  output logic                   o_illegal_fault,
  output logic                   o_virtual_fault,
  output logic                   o_hyper_state_gate,
  output logic [IDX_W-1:0]       o_next_slot_pointer,
  output logic                   o_recorded
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ==========================================================
  // storage and pointer
  logic [WORD_W-1:0] src_mem  [NUM_ENTRIES];
  logic [WORD_W-1:0] tgt_mem  [NUM_ENTRIES];
  logic [WORD_W-1:0] meta_mem [NUM_ENTRIES];
  logic [IDX_W-1:0]  next_slot_pointer;
  logic [CYC_W-1:0]  cycle_counter;
  logic              cycle_count_ok;

  // ==========================================================
  // depth and window decode
  wire logic [2:0]       depth_sel_legal;
  wire logic [IDX_W-1:0] depth_mask;
  wire logic [SEL_W-1:0] eff_select;
  wire logic             sel_in_window;
  wire logic [IDX_W-1:0] logical_idx;
  wire logic             idx_in_depth;
  wire logic [IDX_W-1:0] phys_idx;

  assign depth_sel_legal = (i_depth_sel > DEPTH_SEL_MAX) ? DEPTH_SEL_MAX
                                                         : i_depth_sel;
  // depth - 1, used for wrap and range checks
  assign depth_mask = ~(~DEPTH_MASK_MIN << depth_sel_legal);
  assign eff_select    = i_virt ? i_vs_select : i_sup_select; // R03
  assign sel_in_window = (eff_select >= SEL_FIRST) &&
                         (eff_select <= SEL_LAST); // R01
  assign logical_idx   = IDX_W'(eff_select - SEL_FIRST); // R01
  assign idx_in_depth  = (logical_idx & ~depth_mask) == '0; // R24
  assign phys_idx      = (next_slot_pointer - logical_idx - IDX_ONE)
                         & depth_mask; // R23

  // ==========================================================
  // access gating
  wire logic below_machine;
  wire logic hyper_gate_eff;
  wire logic gate_illegal;
  wire logic gate_virtual;
  wire logic entry_access;
  wire logic clear_request;
  wire logic access_illegal;
  wire logic access_virtual;
  wire logic clear_illegal;
  wire logic clear_virtual;
  wire logic clear_fire;
  wire logic access_ok;

  assign below_machine  = i_priv != PRIV_MACHINE;
  assign hyper_gate_eff = i_hyper_state_gate & i_machine_state_gate; // R15
  assign gate_illegal   = below_machine & ~i_machine_state_gate; // R13
  assign gate_virtual   = ~gate_illegal & i_virt &
                          ~hyper_gate_eff; // R16

  assign entry_access   = i_csr_valid & sel_in_window;
  assign access_illegal = entry_access & gate_illegal; // R13
  assign access_virtual = entry_access & gate_virtual; // R16
  assign access_ok      = entry_access & ~gate_illegal & ~gate_virtual;

  // gating takes priority over the plain mode check on the clear
  assign clear_request  = i_record_clear_op;
  assign clear_illegal  = clear_request & (gate_illegal |
                          (~i_virt & (i_priv == PRIV_USER))); // R12 R13
  assign clear_virtual  = clear_request & ~clear_illegal &
                          (gate_virtual |
                           (i_virt & (i_priv == PRIV_USER))); // R12 R16
  assign clear_fire     = clear_request & ~clear_illegal & ~clear_virtual;

  // ==========================================================
  // qualification of retired transfers
  wire logic base_qual;
  wire logic mode_qual;
  wire logic record_fire;
  wire logic zero_src;
  wire logic zero_tgt;

  assign base_qual = i_retire_valid & ~i_retire_inhibit & ~i_frozen &
                     ~i_in_debug & ~i_debug_crossing; // R17 R22
  assign mode_qual =
    i_retire_is_trap   ? i_tgt_mode_enabled :                  // R20
    i_retire_is_return ? i_src_mode_enabled :                  // R21
                         i_src_mode_enabled;                   // R17
  // recording ignores the software gates, except where they let a same-cycle clear fire
  assign record_fire = base_qual & mode_qual & ~clear_fire; // R14
  assign zero_src = i_retire_is_trap & ~i_src_mode_enabled; // R20
  assign zero_tgt = i_retire_is_return & ~i_tgt_mode_enabled; // R21

  // ==========================================================
  // record composition
  function automatic logic [CYC_W-1:0] encode_count(
    input logic [CYC_W-1:0] raw
  );
    logic [CYC_W-1:0] res;
    res = raw;
    for (int p = MANT_W; p < CYC_W; p++) begin
      if (raw[p]) begin
        res = {4'(p - MANT_W + 1), MANT_W'(raw >> (p - MANT_W))};
      end
    end
    return res; // R09
  endfunction

  wire logic [WORD_W-1:0] width_mask;
  wire logic [WORD_W-1:0] rec_src;
  wire logic [WORD_W-1:0] rec_tgt;
  wire logic [WORD_W-1:0] rec_meta;
  wire logic [WORD_W-1:0] sw_word;

  assign width_mask = i_narrow_width ? LOW_MASK : ~ZERO_WORD; // R05
  assign rec_src  = ((zero_src ? ZERO_WORD : i_retire_src_pc) & width_mask)
                    | (WORD_W'(1) << SRC_VALID_BIT); // R19 R20
  assign rec_tgt  = ((zero_tgt ? ZERO_WORD : i_retire_tgt_pc) & width_mask
                     & ~(WORD_W'(1) << PREDICTOR_MISS_FLAG_BIT))
                    | (WORD_W'(i_retire_mispredict)
                       << PREDICTOR_MISS_FLAG_BIT); // R06
  assign rec_meta = (WORD_W'(i_retire_kind) << META_TYPE_LSB)      // R08
                    | (WORD_W'(cycle_count_ok) << CYCLE_COUNT_OK_BIT) // R11
                    | (WORD_W'(encode_count(cycle_counter))
                       << CYCLE_COUNT_FIELD_LSB);                  // R09
  assign sw_word  = i_csr_wdata & width_mask; // R04 R05

  // ==========================================================
  // software write steering
  wire logic sw_write;
  wire logic sw_src;
  wire logic sw_tgt;
  wire logic sw_meta;

  // a same-cycle record takes the slot, the software write is dropped
  assign sw_write = access_ok & i_csr_write & idx_in_depth &
                    ~record_fire & ~clear_fire; // R24
  assign sw_src   = sw_write & (i_csr_alias == ALIAS_SOURCE); // R02
  assign sw_tgt   = sw_write & (i_csr_alias == ALIAS_TARGET); // R02
  assign sw_meta  = sw_write & (i_csr_alias == ALIAS_META); // R02

  // ==========================================================
  // entry storage, one slot per physical entry
  for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_entry
    wire logic rec_here;
    wire logic sw_here;

    assign rec_here = record_fire && (next_slot_pointer == IDX_W'(e));
    assign sw_here  = phys_idx == IDX_W'(e);

    always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        src_mem[e]  <= ZERO_WORD;
        tgt_mem[e]  <= ZERO_WORD;
        meta_mem[e] <= ZERO_WORD;
      end else if (clear_fire) begin
        src_mem[e]  <= ZERO_WORD; // R10
        tgt_mem[e]  <= ZERO_WORD; // R10
        meta_mem[e] <= ZERO_WORD; // R10
      end else if (rec_here) begin
        src_mem[e]  <= rec_src; // R18 R19
        tgt_mem[e]  <= rec_tgt; // R18
        meta_mem[e] <= rec_meta; // R19
      end else begin
        if (sw_src && sw_here) begin
          src_mem[e] <= sw_word; // R04
        end
        if (sw_tgt && sw_here) begin
          tgt_mem[e] <= sw_word; // R04
        end
        if (sw_meta && sw_here) begin
          meta_mem[e] <= i_csr_wdata & META_WMASK; // R07
        end
      end
    end
  end

  // ==========================================================
  // pointer, cycle counter and count-valid state
  wire logic [IDX_W-1:0] next_pointer;
  wire logic [CYC_W-1:0] next_cycles;

  // wraps at depth-1, the oldest slot is overwritten when full
  assign next_pointer = (next_slot_pointer + IDX_ONE) & depth_mask; // R18
  assign next_cycles  = (cycle_counter == CYC_SAT) ? CYC_SAT
                                                   : cycle_counter + CYC_ONE;

  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      next_slot_pointer <= '0;
      cycle_counter     <= '0;
      cycle_count_ok    <= 1'b0;
    end else if (clear_fire) begin
      cycle_counter  <= '0; // R10
      cycle_count_ok <= 1'b0; // R10 R11
    end else if (record_fire) begin
      next_slot_pointer <= next_pointer; // R18
      cycle_counter     <= '0;
      cycle_count_ok    <= 1'b1;
    end else begin
      next_slot_pointer <= next_slot_pointer & depth_mask;
      cycle_counter     <= next_cycles;
    end
  end

  // ==========================================================
  // read path
  wire logic [WORD_W-1:0] entry_word;
  wire logic [WORD_W-1:0] read_word;

  assign entry_word =
    (i_csr_alias == ALIAS_SOURCE) ? src_mem[phys_idx]  :
    (i_csr_alias == ALIAS_TARGET) ? tgt_mem[phys_idx]  :
    (i_csr_alias == ALIAS_META)   ? meta_mem[phys_idx] :
                                    ZERO_WORD; // R02
  // faulting or out-of-depth reads return zero
  assign read_word = (access_ok && idx_in_depth) ? (entry_word & width_mask)
                                                 : ZERO_WORD; // R24

  // ==========================================================
  // registered answers
  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_csr_done          <= 1'b0;
      o_csr_hit           <= 1'b0;
      o_csr_rdata         <= ZERO_WORD;
      o_illegal_fault     <= 1'b0;
      o_virtual_fault     <= 1'b0;
      o_hyper_state_gate  <= 1'b0;
      o_next_slot_pointer <= '0;
      o_recorded          <= 1'b0;
    end else begin
      o_csr_done          <= i_csr_valid;
      o_csr_hit           <= entry_access;
      o_csr_rdata         <= read_word;
      o_illegal_fault     <= access_illegal | clear_illegal; // R13
      o_virtual_fault     <= access_virtual | clear_virtual; // R16
      o_hyper_state_gate  <= hyper_gate_eff; // R15
      o_next_slot_pointer <= next_slot_pointer;
      o_recorded          <= record_fire;
    end
  end

endmodule

// ==== record_buffer_pkg.sv ====
package record_buffer_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_ENTRIES = 256;
  localparam int unsigned IDX_W       = 8;
  localparam int unsigned WORD_W      = 64;
  localparam int unsigned HALF_W      = 32;
  localparam int unsigned SEL_W       = 12;
  localparam int unsigned CYC_W       = 16;
  localparam int unsigned MANT_W      = 12;

  // ==========================================================
  // indirect select window
  localparam logic [SEL_W-1:0] SEL_FIRST = 12'h200;
  localparam logic [SEL_W-1:0] SEL_LAST  = 12'h2ff;

  // alias register numbers (first .. third)
  localparam logic [2:0] ALIAS_SOURCE = 3'h1;
  localparam logic [2:0] ALIAS_TARGET = 3'h2;
  localparam logic [2:0] ALIAS_META   = 3'h3;

  // ==========================================================
  // depth encoding: depth = 2 ** (field + DEPTH_LOG_BASE)
  localparam int unsigned DEPTH_LOG_BASE = 4;
  localparam logic [2:0]  DEPTH_SEL_MAX  = 3'h4;
  localparam logic [IDX_W-1:0] DEPTH_MASK_MIN = 8'h0f;

  // ==========================================================
  // field positions
  localparam int unsigned SRC_VALID_BIT  = 0;
  localparam int unsigned PREDICTOR_MISS_FLAG_BIT = 0;
  localparam int unsigned META_TYPE_LSB  = 0;
  localparam int unsigned META_TYPE_W    = 4;
  localparam int unsigned CYCLE_COUNT_OK_BIT    = 15;
  localparam int unsigned CYCLE_COUNT_FIELD_LSB = 32;
  localparam logic [WORD_W-1:0] META_WMASK = 64'h0000_ffff_0000_800f;

  // ==========================================================
  // privilege encodings
  localparam logic [1:0] PRIV_USER    = 2'h0;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;

  localparam logic [WORD_W-1:0] ZERO_WORD = 64'h0;
  localparam logic [WORD_W-1:0] LOW_MASK  = 64'h0000_0000_ffff_ffff;
  localparam logic [CYC_W-1:0]  CYC_SAT   = 16'hffff;
  localparam logic [CYC_W-1:0]  CYC_ONE   = 16'h0001;
  localparam logic [IDX_W-1:0]  IDX_ONE   = 8'h01;

endpackage

// ==== record_buffer_properties.sv ====
module record_buffer_properties
  import record_buffer_pkg::*;
(
  // clock, reset and mode
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  input wire logic [1:0]        i_priv,
  input wire logic              i_virt,
  input wire logic              i_machine_state_gate,
  input wire logic              i_hyper_state_gate,
  input wire logic              i_frozen,
  // requests
  input wire logic              i_csr_valid,
  input wire logic [2:0]        i_csr_alias,
  input wire logic [SEL_W-1:0]  i_sup_select,
  input wire logic [SEL_W-1:0]  i_vs_select,
  input wire logic              i_record_clear_op,
  input wire logic              i_retire_valid,
  input wire logic              i_in_debug,
  input wire logic              i_debug_crossing,
  // answers
  input wire logic              o_csr_done,
  input wire logic              o_csr_hit,
  input wire logic [WORD_W-1:0] o_csr_rdata,
  input wire logic              o_illegal_fault,
  input wire logic              o_virtual_fault,
  input wire logic              o_hyper_state_gate,
  input wire logic              o_recorded
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // helpers
  logic [SEL_W-1:0] eff_sel;
  logic             in_win;
  logic             below_m;
  assign eff_sel = i_virt ? i_vs_select : i_sup_select;
  assign in_win  = (eff_sel >= SEL_FIRST) && (eff_sel <= SEL_LAST);
  assign below_m = i_priv != PRIV_MACHINE;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========
  // assertions
  done_after_req_a: assert property (i_csr_valid |=> o_csr_done)
    else $error("access not answered");
  done_has_req_a: assert property (o_csr_done |-> $past(i_csr_valid))
    else $error("answer without access");
  window_hit_a: assert property (i_csr_valid && in_win |=> o_csr_hit)
    else $error("window select not a hit");
  high_alias_zero_a: assert property (i_csr_valid && i_csr_alias > 3'h3
    |=> o_csr_rdata == ZERO_WORD) else $error("high alias not zero");
  hyper_gate_zero_a: assert property (!i_machine_state_gate
    |=> !o_hyper_state_gate) else $error("hyper gate reads one");
  gate_illegal_a: assert property (i_csr_valid && in_win && below_m
    && !i_machine_state_gate |=> o_illegal_fault && o_csr_rdata == ZERO_WORD)
    else $error("gated access not illegal");
  guest_virtual_a: assert property (i_record_clear_op && i_virt && below_m
    && i_machine_state_gate && !i_hyper_state_gate
    |=> o_virtual_fault && !o_illegal_fault) else $error("guest clear");
  record_block_a: assert property (i_retire_valid
    && (i_frozen || i_in_debug || i_debug_crossing) |=> !o_recorded)
    else $error("blocked transfer recorded");
  cover property (o_recorded);
  cover property (o_illegal_fault);
  cover property (o_virtual_fault);
endmodule

bind record_buffer record_buffer_properties chk (
  .i_core_clk, .i_rstn, .i_priv, .i_virt, .i_machine_state_gate,
  .i_hyper_state_gate, .i_frozen, .i_csr_valid, .i_csr_alias,
  .i_sup_select, .i_vs_select, .i_record_clear_op, .i_retire_valid,
  .i_in_debug, .i_debug_crossing, .o_csr_done, .o_csr_hit, .o_csr_rdata,
  .o_illegal_fault, .o_virtual_fault, .o_hyper_state_gate, .o_recorded
);

// ==== retire_model.sv ====
module retire_model
  import record_buffer_pkg::*;
(
  // retire side
  input  wire logic         i_core_clk,
  output logic              o_valid,
  output logic [WORD_W-1:0] o_src,
  output logic [WORD_W-1:0] o_tgt,
  output logic [3:0]        o_kind,
  // {dbgx, dbg, inh, tgt_en, src_en, ret, trap, miss}
  output logic [7:0]        o_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    {o_src, o_tgt, o_kind, o_flags} = '0;
  end
  // idle pcs inverted so a stale pc never looks like a fresh one
  task automatic xfer(input logic [WORD_W-1:0] s, t,
                      input logic [3:0] k, input logic [7:0] f);
    @(negedge i_core_clk);
    o_valid = 1'b1;
    {o_src, o_tgt, o_kind, o_flags} = {s, t, k, f};
    @(negedge i_core_clk);
    o_valid = 1'b0;
    {o_src, o_tgt, o_flags} = {~s, ~t, 8'h00};
  endtask
endmodule

// ==== tb.sv ====
module tb import record_buffer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rstn, virt, narrow, mg, hg, frozen, cv, cw, clr;
  logic [1:0]        priv;
  logic [2:0]        dsel, ca;
  logic [SEL_W-1:0]  ss, vs;
  logic [WORD_W-1:0] wd, rd, got, rs, rt;
  logic              done, hit, ill, vf, hgo, rec, rv;
  logic [IDX_W-1:0]  ptr;
  logic [3:0]        rk;
  logic [7:0]        rf;
  int                err_total, check_count;

  `define CHK(nm, ex, ac) \
    begin \
      check_count++; \
      if ((ac) !== (ex)) begin \
        err_total++; \
        $display("CHECK FAILED %s exp %h seen %h", nm, ex, ac); \
      end \
    end

  retire_model rm (.i_core_clk(clk), .o_valid(rv), .o_src(rs), .o_tgt(rt),
                   .o_kind(rk), .o_flags(rf));
  record_buffer dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_priv(priv), .i_virt(virt),
    .i_narrow_width(narrow), .i_machine_state_gate(mg),
    .i_hyper_state_gate(hg), .i_depth_sel(dsel), .i_frozen(frozen),
    .i_csr_valid(cv), .i_csr_write(cw), .i_csr_alias(ca), .i_csr_wdata(wd),
    .i_sup_select(ss), .i_vs_select(vs), .i_record_clear_op(clr),
    .i_retire_valid(rv), .i_retire_src_pc(rs), .i_retire_tgt_pc(rt),
    .i_retire_kind(rk), .i_retire_mispredict(rf[0]),
    .i_retire_is_trap(rf[1]), .i_retire_is_return(rf[2]),
    .i_src_mode_enabled(rf[3]), .i_tgt_mode_enabled(rf[4]),
    .i_retire_inhibit(rf[5]), .i_in_debug(rf[6]),
    .i_debug_crossing(rf[7]), .o_csr_done(done), .o_csr_hit(hit),
    .o_csr_rdata(rd), .o_illegal_fault(ill), .o_virtual_fault(vf),
    .o_hyper_state_gate(hgo), .o_next_slot_pointer(ptr), .o_recorded(rec));

  // ==========
  // access helpers
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [SEL_W-1:0] s, input logic [WORD_W-1:0] d);
    @(negedge clk);
    {cv, cw, ca, wd} = {1'b1, w, a, d};
    // the unused window gets index 0 so a wrong pick misses
    {ss, vs} = virt ? {12'h000, s} : {s, 12'h000};
    @(negedge clk);
    cv = 1'b0;
    got = rd;
    `CHK("done", 1'b1, done)
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [SEL_W-1:0] s,
                        input logic [WORD_W-1:0] ex);
    acc(1'b0, a, s, '0);
    `CHK("rdata", ex, got)
    `CHK("hit", 1'b1, hit)
  endtask
  task automatic cl;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  task automatic md(input logic [1:0] p, input logic v, m, h);
    {priv, virt, mg, hg} = {p, v, m, h};
  endtask

  // ==========
  // scenarios
  task automatic t_push;
    rm.xfer(64'h1000, 64'h2000, 4'h5, 8'h19);
    `CHK("rec", 1'b1, rec)
    rm.xfer(64'h3000, 64'h4000, 4'h9, 8'h18);
    chk_rd(3'h1, 12'h200, 64'h3001);
    `CHK("ptr", 8'h02, ptr)
    chk_rd(3'h1, 12'h201, 64'h1001);
    chk_rd(3'h2, 12'h201, 64'h2001);
    acc(1'b0, 3'h3, 12'h201, '0);
    `CHK("meta", 64'h5, got & 64'h800f)
    acc(1'b0, 3'h3, 12'h200, '0);
    `CHK("meta", 64'h8009, got & 64'h800f)
    `CHK("count", 16'h0001, got[47:32])
  endtask
  task automatic t_alias;
    for (int a = 4; a < 7; a++) begin
      acc(1'b1, 3'(a), 12'h200, '1);
      chk_rd(3'(a), 12'h200, 64'h0);
    end
  endtask
  task automatic t_guest;
    md(2'h1, 1'b1, 1'b1, 1'b1);
    chk_rd(3'h1, 12'h201, 64'h1001);
    hg = 1'b0;
    chk_rd(3'h1, 12'h200, 64'h0);
    `CHK("vfault", 1'b1, vf)
    cl();
    `CHK("vfault", 1'b1, vf)
  endtask
  task automatic t_faults;
    md(2'h0, 1'b0, 1'b1, 1'b1);
    cl();
    `CHK("ill", 1'b1, ill)
    virt = 1'b1;
    cl();
    `CHK("vfault", 1'b1, vf)
    md(2'h1, 1'b0, 1'b0, 1'b1);
    cl();
    `CHK("ill", 1'b1, ill)
    acc(1'b1, 3'h1, 12'h200, '0);
    `CHK("ill", 1'b1, ill)
    `CHK("hgate", 1'b0, hgo)
    rm.xfer(64'h5000, 64'h6000, 4'hb, 8'h18);
    `CHK("rec", 1'b1, rec)
    mg = 1'b1;
    chk_rd(3'h1, 12'h200, 64'h5001);
    `CHK("hgate", 1'b1, hgo)
    chk_rd(3'h1, 12'h201, 64'h3001);
  endtask
  task automatic t_filter;
    logic [7:0] bad [4] = '{8'h38, 8'h58, 8'h98, 8'h10};
    frozen = 1'b1;
    rm.xfer(64'h7000, 64'h7100, 4'h5, 8'h18);
    `CHK("rec", 1'b0, rec)
    frozen = 1'b0;
    foreach (bad[i]) begin
      rm.xfer(64'h7000, 64'h7100, 4'h5, bad[i]);
      `CHK("rec", 1'b0, rec)
    end
  endtask
  task automatic t_trap;
    logic [7:0] fl [4] = '{8'h12, 8'h0a, 8'h0c, 8'h14};
    logic       ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    foreach (fl[i]) begin
      rm.xfer(64'h8000, 64'h9000, 4'h1, fl[i]);
      `CHK("rec", ex[i], rec)
    end
    chk_rd(3'h1, 12'h201, 64'h1);
    chk_rd(3'h2, 12'h200, 64'h0);
    chk_rd(3'h1, 12'h200, 64'h8001);
  endtask
  task automatic t_clear;
    cl();
    `CHK("ill", 1'b0, ill)
    for (int a = 1; a < 4; a++) chk_rd(3'(a), 12'h200, 64'h0);
    chk_rd(3'h1, 12'h2ff, 64'h0);
    rm.xfer(64'ha000, 64'hb000, 4'hd, 8'h18);
    acc(1'b0, 3'h3, 12'h200, '0);
    `CHK("meta", 64'hd, got & 64'h800f)
  endtask
  task automatic t_width;
    narrow = 1'b1;
    acc(1'b1, 3'h1, 12'h200, 64'hdead_beef_1234_5679);
    rm.xfer(64'hffff_0000_0000_c000, 64'h0, 4'h5, 8'h18);
    narrow = 1'b0;
    chk_rd(3'h1, 12'h201, 64'h1234_5679);
    chk_rd(3'h1, 12'h200, 64'hc001);
    dsel = 3'h0;
    acc(1'b1, 3'h1, 12'h210, 64'h4);
    chk_rd(3'h1, 12'h210, 64'h0);
    chk_rd(3'h1, 12'h200, 64'hc001);
    acc(1'b0, 3'h1, 12'h300, '0);
    `CHK("hit", 1'b0, hit)
    `CHK("rdata", 64'h0, got)
  endtask

  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is about 115 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    {rstn, priv, dsel, ca} = {1'b0, 2'h1, 3'h4, 3'h1};
    {virt, narrow, frozen, cv, cw, clr, mg, hg} = 8'h03;
    {wd, ss, vs, err_total, check_count} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("ptr", 8'h00, ptr)
    t_push();
    t_alias();
    t_guest();
    t_faults();
    t_filter();
    t_trap();
    t_clear();
    t_width();
    results();
  end
endmodule
